// File: hw/wdt_consts.svh
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// register indices; byte address is four times the index
`define WDT_IDX_KEY 16'hF010
`define WDT_IDX_MODE 16'hF012
`define WDT_IDX_COUNT 16'hF014
`define WDT_IDX_WSTAT 16'hF016
`define WDT_IDX_IRQ_STATUS 16'hF018
`define WDT_IDX_IRQ_MASK 16'hF01A

// reset values
`define WDT_MODE_RESET 8'h06
`define WDT_WSTAT_RESET 1'b1
`define WDT_COUNT_RESET 16'h0000

// mode register fields and writable bits
`define WDT_MODE_WMASK 8'h37
`define WDT_PERIOD_LSB 0
`define WDT_WINDOW_LSB 4

// clear keys and the handler exception level
`define WDT_KEY_FIRST 8'h5A
`define WDT_KEY_SECOND 8'hA5
`define WDT_EXCEPTION_LEVEL_HANDLER 2'h2

// shortest period code for which a window may apply
`define WDT_MIN_WIN_PERIOD 3'h4

// watchdog count clock rate in Hz
`define WDT_CLK_HZ 1024

// interrupt status bit positions
`define WDT_IRQ_OVF 0
`define WDT_IRQ_CLR 1

`endif

// File: hw/wdt_pkg.sv
package wdt_pkg;

    // overflow stage reached since the last clear
    typedef enum logic [0:0] {
        STAGE_FIRST = 1'b0,
        STAGE_SECOND = 1'b1
    } stage_type;

endpackage

// File: hw/windowed_watchdog_timer.sv
// Local design decision: the APB slave port.
`timescale 1ns/10ps
`include "wdt_consts.svh"
// Contract
// - no window: interrupt first, reset second
// - window on: reset at first overflow
// - window on: clear while closed resets
// - period code selects eight overflow times
// - window code selects open share
// - periods up to 62.5 ms: no window
// - clear only on 0x5A then 0xA5
// - pointer zero on overflow, toggles on write
// - key register reads pointer in bit 0
// - no clearing while exception level two
// - live counter readable read-only
// - status one while clearing is permitted
// - static inputs gate enable and halts
// - count watchdog clock edges after reset
// - counter restarts from zero after overflow
// - each reset sets own cause flag
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dedicated watchdog count clock pin
    input wire logic watchdog_clock,
    // cpu state and static options
    input wire logic [1:0] exception_level,
    input wire logic wdt_enable,
    input wire logic halt_mode,
    input wire logic halt_run_enable,
    input wire logic halt_deep_mode,
    input wire logic halt_deep_run_enable,
    // interrupt and reset requests
    output logic wdt_irq,
    output logic overflow_reset_cause,
    output logic bad_clear_reset_cause,
    output logic system_reset_req
);

    // bus decode
    logic [15:0] index; // register index from byte address
    logic setup_phase; // first cycle of a transfer
    logic access_done; // edge at which the transfer completes
    logic wr_done; // completing write
    logic rd_done; // completing read
    logic hit_key;
    logic hit_mode;
    logic hit_count;
    logic hit_wstat;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic hit_any; // address is mapped
    logic [31:0] read_word; // read data mux

    // software state
    logic [7:0] period_window_mode; // window and period fields
    logic key_pointer; // internal key pointer
    logic key_armed; // first key accepted
    logic [1:0] irq_status; // sticky events
    logic [1:0] irq_mask; // event enables
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask; // mask after this cycle's write

    // count clock synchroniser and edge detect
    logic wclk_sync1; // metastability stage, read by wclk_sync2 only
    logic wclk_sync2;
    logic wclk_prev;
    logic tick; // one pclk pulse per watchdog clock rise
    logic run; // counting allowed by static options

    // counter and window
    logic [15:0] counter_readback; // live watchdog count
    stage_type stage; // overflow stage since last clear
    logic clear_permitted; // registered window status
    logic next_permitted;
    logic [2:0] period_select;
    logic [1:0] window_select;
    logic [3:0] period_shift; // log2 of ticks per period
    logic [15:0] period_last; // count value just before overflow
    logic [15:0] closed_len; // ticks during which clearing is barred
    logic win_active; // window function in force

    // key and overflow events
    logic wr_key;
    logic good_key; // complete, accepted clear sequence
    logic key_clear; // sequence clears the counter
    logic bad_clear; // sequence lands while window is closed
    logic overflow; // counter wraps this cycle
    logic ovf_irq_evt; // first overflow without window
    logic ovf_reset_evt; // overflow that ends in reset

    // setup cycle registers the answer, so every transfer has no wait state
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign wr_done = access_done & pwrite;
    assign rd_done = access_done & ~pwrite;
    assign index = paddr[17:2];
    assign hit_key = (index == `WDT_IDX_KEY);
    assign hit_mode = (index == `WDT_IDX_MODE);
    assign hit_count = (index == `WDT_IDX_COUNT);
    assign hit_wstat = (index == `WDT_IDX_WSTAT);
    assign hit_irq_status = (index == `WDT_IDX_IRQ_STATUS);
    assign hit_irq_mask = (index == `WDT_IDX_IRQ_MASK);
    assign hit_any = hit_key | hit_mode | hit_count | hit_wstat
                   | hit_irq_status | hit_irq_mask;

    // read data; reserved bits read as zero
    assign read_word = hit_key ? {31'h00000000, key_pointer} :
                       hit_mode ? {24'h000000, period_window_mode} :
                       hit_count ? {16'h0000, counter_readback} :
                       hit_wstat ? {31'h00000000, clear_permitted} :
                       hit_irq_status ? {30'h00000000, irq_status} :
                       hit_irq_mask ? {30'h00000000, irq_mask} :
                       32'h00000000;

    // bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & ~hit_any;
            prdata <= (setup_phase & ~pwrite) ? read_word : 32'h00000000;
        end
    end

    // mode fields
    assign period_select = period_window_mode[`WDT_PERIOD_LSB +: 3];
    assign window_select = period_window_mode[`WDT_WINDOW_LSB +: 2];
    // short periods never run windowed, whatever the window field holds
    assign win_active = (window_select != 2'h0)
                      & (period_select >= `WDT_MIN_WIN_PERIOD);
    // ticks are 8,16,32,64,128 then 512,2048,8192 at the count clock rate
    assign period_shift = (period_select < 3'h5) ?
                          ({1'b0, period_select} + 4'h3) :
                          ({period_select, 1'b0} - 4'h1);
    assign period_last = (16'h0001 << period_shift) - 16'h0001;
    // mode 1 closes a quarter, modes 2 and 3 close half of the period
    assign closed_len = (window_select == 2'h1) ?
                        (16'h0001 << (period_shift - 4'h2)) :
                        (16'h0001 << (period_shift - 4'h1));
    // window open once the closed part has elapsed since the last clear
    assign next_permitted = ~win_active
                          | (counter_readback >= closed_len);

    // mode register; key register holds no data beyond the pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_window_mode <= `WDT_MODE_RESET;
        end else if (wr_done & hit_mode & pstrb[0]) begin
            period_window_mode <= pwdata[7:0] & `WDT_MODE_WMASK;
        end
    end

    // key sequence decode; handler level blocks the clear itself
    assign wr_key = wr_done & hit_key & pstrb[0];
    assign good_key = wr_key & key_pointer & key_armed
                    & (pwdata[7:0] == `WDT_KEY_SECOND)
                    & (exception_level != `WDT_EXCEPTION_LEVEL_HANDLER);
    assign key_clear = good_key & clear_permitted;
    assign bad_clear = good_key & ~clear_permitted;

    // static options decide whether the count runs at all
    assign run = wdt_enable
               & ~(halt_mode & ~halt_run_enable)
               & ~(halt_deep_mode & ~halt_deep_run_enable);
    // a key clear in the same cycle wins over the wrap
    // compare with >= so that shortening the period above the count
    // wraps at the next tick instead of running on to the 16-bit limit
    assign overflow = tick & run & ~good_key
                    & (counter_readback >= period_last);
    assign ovf_irq_evt = overflow & ~win_active
                       & (stage == STAGE_FIRST);
    assign ovf_reset_evt = overflow
                         & (win_active | (stage == STAGE_SECOND));

    // key pointer and first-key flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_pointer <= 1'b0;
            key_armed <= 1'b0;
        end else if (overflow) begin
            key_pointer <= 1'b0;
            key_armed <= 1'b0;
        end else if (wr_key) begin
            key_pointer <= ~key_pointer;
            key_armed <= ~key_pointer
                       & (pwdata[7:0] == `WDT_KEY_FIRST);
        end
    end

    // two-stage synchroniser on the count clock pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wclk_sync1 <= 1'b0;
            wclk_sync2 <= 1'b0;
            wclk_prev <= 1'b0;
        end else begin
            wclk_sync1 <= watchdog_clock;
            wclk_sync2 <= wclk_sync1;
            wclk_prev <= wclk_sync2;
        end
    end

    // rising edge only; pclk must be well above the count clock rate
    assign tick = wclk_sync2 & ~wclk_prev;

    // watchdog counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_readback <= `WDT_COUNT_RESET;
        end else if (key_clear | overflow) begin
            counter_readback <= 16'h0000;
        end else if (tick & run) begin
            counter_readback <= counter_readback + 16'h0001;
        end
    end

    // overflow stage; a clear or a reset request starts over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage <= STAGE_FIRST;
        end else if (key_clear | ovf_reset_evt | bad_clear) begin
            stage <= STAGE_FIRST;
        end else if (ovf_irq_evt) begin
            stage <= STAGE_SECOND;
        end
    end

    // window status follows the count one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_permitted <= `WDT_WSTAT_RESET;
        end else begin
            clear_permitted <= next_permitted;
        end
    end

    // reset requests: one-cycle pulses with their own cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_reset_cause <= 1'b0;
            bad_clear_reset_cause <= 1'b0;
            system_reset_req <= 1'b0;
        end else begin
            overflow_reset_cause <= ovf_reset_evt;
            bad_clear_reset_cause <= bad_clear;
            system_reset_req <= ovf_reset_evt | bad_clear;
        end
    end

    // sticky events; a read clears only the bits it returned, so an event
    // landing at the setup edge is kept for the next read, and a new event
    // beats the read that clears
    assign next_irq_status =
        ((rd_done & hit_irq_status) ? (irq_status & ~prdata[1:0]) : irq_status)
        | {key_clear, ovf_irq_evt};

    // mask as it stands after this edge, so the output never lags a mask write
    assign next_irq_mask = (wr_done & hit_irq_mask & pstrb[0]) ? pwdata[1:0] : irq_mask;

    // interrupt status, mask and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 2'h0;
            irq_mask <= 2'h0;
            wdt_irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            // built from next values so the level matches the registers
            wdt_irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_first_ovf;
        overflow && !win_active && stage == STAGE_FIRST;
    endsequence

    sequence seq_overflow_reset;
        overflow_reset_cause && system_reset_req && !bad_clear_reset_cause;
    endsequence

    AST_FIRST_OVF_IRQ: assert property (
        seq_first_ovf |=> irq_status[`WDT_IRQ_OVF] && !system_reset_req
    ) else $error("first overflow without window gave no interrupt");

    AST_SECOND_OVF_RST: assert property (
        overflow && !win_active && stage == STAGE_SECOND |=> seq_overflow_reset
    ) else $error("second overflow gave no reset");

    AST_WIN_OVF_RST: assert property (
        overflow && win_active |=> seq_overflow_reset ##1 !system_reset_req
    ) else $error("windowed overflow gave no single reset pulse");

    AST_BAD_CLEAR: assert property (
        good_key && !clear_permitted |=> bad_clear_reset_cause && system_reset_req
    ) else $error("clear in closed window gave no reset");

    AST_KEY_CLEAR: assert property (
        good_key && clear_permitted |=> counter_readback == 16'h0000 && !system_reset_req
    ) else $error("valid key sequence did not clear counter");

    AST_PTR_TOGGLE: assert property (
        wr_key && !overflow |=> key_pointer != $past(key_pointer)
    ) else $error("key pointer did not toggle on write");

    AST_PTR_OVF: assert property (
        overflow |=> !key_pointer && counter_readback == 16'h0000
    ) else $error("overflow did not reset pointer and counter");

    AST_EXCEPTION_LEVEL: assert property (
        wr_key && exception_level == `WDT_EXCEPTION_LEVEL_HANDLER
        |=> !bad_clear_reset_cause && $stable(irq_status[`WDT_IRQ_CLR])
    ) else $error("clear attempt honoured in handler level");

    AST_SHORT_NOWIN: assert property (
        period_select < `WDT_MIN_WIN_PERIOD |-> !win_active ##1 clear_permitted
    ) else $error("window active on short period");

    AST_IRQ_LEVEL: assert property (
        wdt_irq == |(irq_status & irq_mask)
    ) else $error("interrupt level does not follow unmasked status");

    AST_STATUS_NOWIN: assert property (
        !win_active [*2] |-> clear_permitted
    ) else $error("status low while window inactive");

endmodule

// File: tb/windowed_watchdog_timer_tb_top.sv
`timescale 1ns/10ps
`include "wdt_consts.svh"
module windowed_watchdog_timer_tb_top;
    // clock, reset and bus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr;
    // count clock, cpu state and options
    logic watchdog_clock = 1'b0;
    logic [1:0] exception_level = 2'h0;
    logic wdt_enable = 1'b1, halt_mode = 1'b0, halt_run_enable = 1'b0;
    logic halt_deep_mode = 1'b0, halt_deep_run_enable = 1'b0;
    // interrupt and reset requests
    logic wdt_irq, overflow_reset_cause, bad_clear_reset_cause, system_reset_req;
    // bookkeeping
    int n_mismatch = 0, num_checks = 0, cycles = 0;
    int n_ovf = 0, n_bad = 0, n_sys = 0;
    logic [31:0] rd;
    logic err;

    windowed_watchdog_timer i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .watchdog_clock(watchdog_clock), .exception_level(exception_level),
        .wdt_enable(wdt_enable), .halt_mode(halt_mode), .halt_run_enable(halt_run_enable),
        .halt_deep_mode(halt_deep_mode), .halt_deep_run_enable(halt_deep_run_enable),
        .wdt_irq(wdt_irq), .overflow_reset_cause(overflow_reset_cause),
        .bad_clear_reset_cause(bad_clear_reset_cause), .system_reset_req(system_reset_req)
    );

    // 25 MHz bus clock
    always #20 pclk = ~pclk;

    // reset pulses last one cycle, so tally them here instead of polling
    always @(posedge pclk) begin
        if (overflow_reset_cause === 1'b1) n_ovf++;
        if (bad_clear_reset_cause === 1'b1) n_bad++;
        if (system_reset_req === 1'b1) n_sys++;
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, entered just after a rising edge; the request holds until
    // pready is seen high at a rising edge, then one idle edge keeps strobes apart
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic key_clear();
        apb(1'b1, `WDT_IDX_KEY, 32'h5A);
        apb(1'b1, `WDT_IDX_KEY, 32'hA5);
    endtask

    // each count clock period spans eight bus cycles so the synchroniser keeps up
    task automatic tick(input int n);
        repeat (n) begin
            watchdog_clock <= 1'b1;
            repeat (4) @(posedge pclk);
            watchdog_clock <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (2) @(posedge pclk);
    endtask

    // reset values, read-only counter, unmapped place, pointer toggle
    task automatic t_reset_regs();
        rdchk("mode", `WDT_IDX_MODE, 32'h06);
        rdchk("key", `WDT_IDX_KEY, 32'h0);
        rdchk("wstat", `WDT_IDX_WSTAT, 32'h1);
        apb(1'b1, `WDT_IDX_COUNT, 32'h1234);
        rdchk("count", `WDT_IDX_COUNT, 32'h0);
        apb(1'b0, 16'hF01C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, `WDT_IDX_MODE, 32'hFF);
        rdchk("mode_bits", `WDT_IDX_MODE, 32'h37);
        pstrb <= 4'hE;
        apb(1'b1, `WDT_IDX_MODE, 32'h00);
        pstrb <= 4'hF;
        rdchk("strb_off", `WDT_IDX_MODE, 32'h37);
        apb(1'b1, `WDT_IDX_MODE, 32'h00);
        apb(1'b1, `WDT_IDX_KEY, 32'h12);
        rdchk("ptr_one", `WDT_IDX_KEY, 32'h1);
    endtask

    // counting, key clear and the interrupt raised, masked and cleared
    task automatic t_clear_irq();
        apb(1'b1, `WDT_IDX_KEY, 32'h12);
        tick(5);
        rdchk("count5", `WDT_IDX_COUNT, 32'h5);
        apb(1'b1, `WDT_IDX_KEY, 32'hA5);
        rdchk("a5_alone", `WDT_IDX_COUNT, 32'h5);
        apb(1'b1, `WDT_IDX_KEY, 32'hA5);
        key_clear();
        rdchk("cleared", `WDT_IDX_COUNT, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, wdt_irq});
        apb(1'b1, `WDT_IDX_IRQ_MASK, 32'h2);
        chk("irq_on", 32'h1, {31'h0, wdt_irq});
        rdchk("irq_stat", `WDT_IDX_IRQ_STATUS, 32'h2);
        @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, wdt_irq});
    endtask

    // no window: interrupt at the first overflow, reset at the second
    task automatic t_no_window();
        apb(1'b1, `WDT_IDX_IRQ_MASK, 32'h1);
        apb(1'b1, `WDT_IDX_KEY, 32'h5A);
        tick(8);
        chk("irq_first", 32'h1, {31'h0, wdt_irq});
        chk("no_reset", 32'h0, n_sys);
        rdchk("ptr_ovf", `WDT_IDX_KEY, 32'h0);
        rdchk("restart", `WDT_IDX_COUNT, 32'h0);
        rdchk("ovf_stat", `WDT_IDX_IRQ_STATUS, 32'h1);
        tick(8);
        chk("ovf_rst", 32'h1, n_ovf);
        chk("sys_rst", 32'h1, n_sys);
    endtask

    // window half: closed early, bad clear resets, open late, reset at first overflow
    task automatic t_window();
        apb(1'b1, `WDT_IDX_MODE, 32'h24);
        tick(2);
        rdchk("closed", `WDT_IDX_WSTAT, 32'h0);
        key_clear();
        repeat (3) @(posedge pclk);
        chk("bad_rst", 32'h1, n_bad);
        chk("sys_bad", 32'h2, n_sys);
        rdchk("not_clr", `WDT_IDX_COUNT, 32'h2);
        tick(61);
        rdchk("edge63", `WDT_IDX_WSTAT, 32'h0);
        tick(1);
        rdchk("edge64", `WDT_IDX_WSTAT, 32'h1);
        key_clear();
        rdchk("win_clr", `WDT_IDX_COUNT, 32'h0);
        rdchk("reclosed", `WDT_IDX_WSTAT, 32'h0);
        chk("no_bad", 32'h1, n_bad);
        tick(128);
        chk("win_ovf", 32'h2, n_ovf);
        chk("no_irq", 32'h0, {31'h0, wdt_irq});
        rdchk("no_stat", `WDT_IDX_IRQ_STATUS, 32'h2);
    endtask

    // quarter window, code 11 like 10, short period without window
    task automatic t_window_modes();
        apb(1'b1, `WDT_IDX_MODE, 32'h14);
        tick(31);
        rdchk("q31", `WDT_IDX_WSTAT, 32'h0);
        tick(1);
        rdchk("q32", `WDT_IDX_WSTAT, 32'h1);
        apb(1'b1, `WDT_IDX_MODE, 32'h34);
        rdchk("code11", `WDT_IDX_WSTAT, 32'h0);
        apb(1'b1, `WDT_IDX_MODE, 32'h23);
        rdchk("short", `WDT_IDX_WSTAT, 32'h1);
    endtask

    // handler level blocks clearing; enable and halt options gate counting
    task automatic t_level_gates();
        apb(1'b1, `WDT_IDX_MODE, 32'h07);
        key_clear();
        tick(3);
        exception_level <= `WDT_EXCEPTION_LEVEL_HANDLER;
        key_clear();
        rdchk("handler", `WDT_IDX_COUNT, 32'h3);
        exception_level <= 2'h0;
        wdt_enable <= 1'b0;
        tick(2);
        rdchk("disabled", `WDT_IDX_COUNT, 32'h3);
        wdt_enable <= 1'b1;
        halt_mode <= 1'b1;
        tick(2);
        rdchk("halt_stop", `WDT_IDX_COUNT, 32'h3);
        halt_run_enable <= 1'b1;
        tick(2);
        rdchk("halt_run", `WDT_IDX_COUNT, 32'h5);
        halt_mode <= 1'b0;
        halt_deep_mode <= 1'b1;
        tick(2);
        rdchk("deep_stop", `WDT_IDX_COUNT, 32'h5);
        halt_deep_run_enable <= 1'b1;
        tick(1);
        rdchk("deep_run", `WDT_IDX_COUNT, 32'h6);
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_regs();
        t_clear_irq();
        t_no_window();
        t_window();
        t_window_modes();
        t_level_gates();
        test_done();
    end
endmodule
